/* logic/ufc_pkg.sv */
/*
 * constants for the usb function control register: offsets, field positions,
 * reset values and timing counts.
 * assumes a 32-bit apb slave with the register in the low byte of one word.
 */
package ufc_pkg;
	// byte address of the single control register
	localparam logic [7:0] UFC_CTRL_OFFSET   = 8'h00;
	// field positions, most significant first
	localparam int         UFC_BIT_CONNECT   = 7;
	localparam int         UFC_BIT_IRSEL     = 6;
	localparam int         UFC_BIT_WAKEUP    = 5;
	localparam int         UFC_BIT_RSTLINK   = 4;
	localparam int         UFC_BIT_RSV_HI    = 3;
	localparam int         UFC_BIT_RSV_LO    = 2;
	localparam int         UFC_BIT_SETUP     = 1;
	localparam int         UFC_BIT_DIR       = 0;
	// reset value: only the reset link bit comes up set
	localparam logic [7:0] UFC_CTRL_RESET    = 8'h10;
	// writable mask keeps the reserved bits at zero
	localparam logic [7:0] UFC_CTRL_WMASK    = 8'hf3;
	// wakeup pulse length
	localparam int         UFC_CLK_MHZ       = 125;
	localparam int         UFC_WAKE_NS       = 80;
	localparam int         UFC_WAKE_CYCLES   = (UFC_WAKE_NS * UFC_CLK_MHZ + 999) / 1000;
endpackage

/* logic/ufc_usb_function_control.sv */
/*
 * usb function control register with apb slave, remote wakeup pulse
 * generator and function reset routing to the microcontroller.
 * assumes rst_n is the power-up reset only; usb function reset arrives
 * as a plain synchronous input and never clears this register.
 */
`timescale 1ns/1ps
module ufc_usb_function_control
	import ufc_pkg::*;
#(
	parameter int WAKE_CYCLES = UFC_WAKE_CYCLES
) (
	// clock and power-up reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// usb function reset from the usb engine
	input  wire logic        usbFuncReset,
	// controls toward the rest of the device
	output logic             mcuReset,
	output logic             wakeupPulse,
	output logic             irEnable,
	output logic             pullupEnable,
	output logic             xferDirIn,
	output logic             setupInService
);
	localparam logic [7:0] WAKE_LAST = 8'(WAKE_CYCLES - 1);
	// clears the wakeup position: that bit is a strobe, never a stored value
	localparam logic [7:0] WAKE_CLR  = ~(8'h01 << UFC_BIT_WAKEUP);

	logic [7:0]  ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        mcuReset_q, mcuReset_d;
	logic        wake_q, wake_d;
	logic [7:0]  wakeCnt_q, wakeCnt_d;
	logic [8:0]  wakeSeen_q, wakeSeen_d;
	logic        access, hit, wrLow;

	// one wait state: pready asserts the cycle after penable rises
	assign access = psel && penable && !pready_q;
	assign hit    = (paddr == UFC_CTRL_OFFSET);
	assign wrLow  = access && pwrite && hit && pstrb[0];

	// register file and bus answer
	always_comb begin
		ctrl_d    = ctrl_q;
		prdata_d  = prdata_q;
		pready_d  = access;
		pslverr_d = access && !hit; // unmapped address answers with error
		if (wrLow) begin
			// reserved bits masked off, wakeup bit never stored
			ctrl_d = pwdata[7:0] & UFC_CTRL_WMASK & WAKE_CLR;
		end
		if (access && !pwrite) begin
			// wakeup bit reads set while its pulse runs
			prdata_d = hit ? {24'h000000, ctrl_q | (8'(wake_q) << UFC_BIT_WAKEUP)} : 32'h00000000;
		end
	end

	// wakeup pulse: a write of 1 starts it, a write of 0 is ignored
	always_comb begin
		wake_d    = wake_q;
		wakeCnt_d = wakeCnt_q;
		if (wake_q) begin
			if (wakeCnt_q == WAKE_LAST) begin
				wake_d    = 1'b0;
				wakeCnt_d = 8'h00;
			end else begin
				wakeCnt_d = wakeCnt_q + 8'h01;
			end
		end else if (wrLow && pwdata[UFC_BIT_WAKEUP]) begin
			wake_d    = 1'b1;
			wakeCnt_d = 8'h00;
		end
	end

	// usb function reset reaches the mcu only when linked
	always_comb begin
		mcuReset_d = usbFuncReset && ctrl_q[UFC_BIT_RSTLINK];
	end

	// only the power-up reset clears state; usbFuncReset is not used here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= UFC_CTRL_RESET;
			prdata_q   <= 32'h00000000;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			mcuReset_q <= 1'b0;
			wake_q     <= 1'b0;
			wakeCnt_q  <= 8'h00;
		end else begin
			ctrl_q     <= ctrl_d;
			prdata_q   <= prdata_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
			mcuReset_q <= mcuReset_d;
			wake_q     <= wake_d;
			wakeCnt_q  <= wakeCnt_d;
		end
	end

	// outputs straight from flip-flops
	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign mcuReset       = mcuReset_q;
	assign wakeupPulse    = wake_q;
	assign irEnable       = ctrl_q[UFC_BIT_IRSEL];
	assign pullupEnable   = ctrl_q[UFC_BIT_CONNECT];
	assign xferDirIn      = ctrl_q[UFC_BIT_DIR];
	assign setupInService = ctrl_q[UFC_BIT_SETUP];

	// helper count of pulse cycles, kept apart from the pulse's own counter
	// so that the length check does not lean on the logic it is checking
	always_comb begin
		wakeSeen_d = 9'h000;
		if (wake_q) begin
			wakeSeen_d = wakeSeen_q + 9'h001;
		end
	end

	// helper count register, restarts whenever the pulse is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wakeSeen_q <= 9'h000;
		end else begin
			wakeSeen_q <= wakeSeen_d;
		end
	end

	// reserved bits never become set
	AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_q[UFC_BIT_RSV_HI:UFC_BIT_RSV_LO] == 2'b00)
		else $error("reserved bits not zero");

	// write of 1 to wakeup gives a pulse of exact length
	AST_WAKE_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(wake_q) |-> wakeSeen_q == 9'(WAKE_CYCLES))
		else $error("wakeup pulse length wrong");

	AST_WAKE_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wrLow && pwdata[UFC_BIT_WAKEUP] && !wake_q) |=> wake_q)
		else $error("wakeup pulse not started");

	// no pulse without a write of 1
	AST_WAKE_NOCAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(wake_q) |-> $past(wrLow) && $past(pwdata[UFC_BIT_WAKEUP]))
		else $error("wakeup pulse without request");

	// stored wakeup bit stays clear
	AST_WAKE_SELFCLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl_q[UFC_BIT_WAKEUP])
		else $error("wakeup bit stored");

	// a read during the pulse shows the request still in progress
	AST_WAKE_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(access && !pwrite && hit && wake_q) |=> prdata[UFC_BIT_WAKEUP])
		else $error("wakeup in progress not readable");

	AST_MCU_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mcuReset_q == $past(usbFuncReset && ctrl_q[UFC_BIT_RSTLINK]))
		else $error("mcu reset routing wrong");

	// with the link bit clear the mcu never sees a function reset
	AST_LINK_APART: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl_q[UFC_BIT_RSTLINK] |=> !mcuReset)
		else $error("mcu reset while unlinked");

	// usb function reset alone never changes the register
	AST_USB_RST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($past(!wrLow) && usbFuncReset) |-> $stable(ctrl_q))
		else $error("register changed without write");

	AST_WRITE_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wrLow |=> ctrl_q == ($past(pwdata[7:0]) & 8'hd3))
		else $error("written value not stored");

	// connect, ir and direction outputs follow the last write, not merely the flop behind them
	AST_PULLUP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wrLow |=> pullupEnable == $past(pwdata[UFC_BIT_CONNECT])
			&& irEnable == $past(pwdata[UFC_BIT_IRSEL])
			&& xferDirIn == $past(pwdata[UFC_BIT_DIR]))
		else $error("connect, ir or direction output wrong");

	// upper read lanes carry no state, so they stay zero
	AST_RDATA_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data not zero");

	// one wait state: the answer follows the first access cycle
	AST_READY_ANSWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(psel && $rose(penable)) |=> pready)
		else $error("no answer after one wait state");

	// the answer lasts one cycle, so a held request is not taken twice
	AST_READY_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pready |=> !pready)
		else $error("ready longer than one cycle");

	AST_ERR_WITH_READY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("error without ready");

	// unmapped address: error answer and the register left alone
	AST_ERR_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(access && !hit) |=> pslverr && $stable(ctrl_q))
		else $error("unmapped access not refused");

	// lane 0 strobe low: the write is dropped and starts no pulse
	AST_STRB_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(access && pwrite && !pstrb[0]) |=> $stable(ctrl_q) && !$rose(wake_q))
		else $error("write without lane strobe landed");
endmodule

/* verif/test_usb_function_control_register.sv */
/* bench for the control register: apb reads and writes via the firmware model.
   assumes the register at offset 0 and a short wakeup pulse parameter. */
`timescale 1ns/1ps
module test_usb_function_control_register
	import ufc_pkg::*;
();
	localparam int WAKE = 8;
	logic clk_sys = 1'b0, rst_n = 1'b0, usbFuncReset = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, mcuReset, wakeupPulse;
	logic irEnable, pullupEnable, xferDirIn, setupInService, e;
	logic [7:0]  paddr;
	logic [3:0]  pstrb, outs;
	logic [31:0] pwdata, prdata, q;
	int          num_errors = 0, checks_done = 0, pulseCnt = 0, p0;
	always #4 clk_sys = ~clk_sys;
	// counts cycles of wakeup pulse seen
	always @(posedge clk_sys) if (wakeupPulse === 1'b1) pulseCnt <= pulseCnt + 1;
	// register outputs gathered for one compare
	assign outs = {pullupEnable, irEnable, setupInService, xferDirIn};
	ufc_fw_master u_fw (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	ufc_usb_function_control #(.WAKE_CYCLES(WAKE)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usbFuncReset(usbFuncReset), .mcuReset(mcuReset), .wakeupPulse(wakeupPulse),
		.irEnable(irEnable), .pullupEnable(pullupEnable), .xferDirIn(xferDirIn),
		.setupInService(setupInService));
	task automatic chkWord(input string s, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic chkBit(input string s, input logic x, input logic g);
		chkWord(s, {31'h0, x}, {31'h0, g});
	endtask
	task automatic rd(input string s, input logic [31:0] x);
		u_fw.xfer(1'b0, UFC_CTRL_OFFSET, 32'h0, q, e);
		chkWord(s, x, q);
	endtask
	task automatic give_verdict();
		num_errors += u_fw.timeouts;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd("reset value", 32'h10);
		usbFuncReset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chkBit("mcu reset linked", 1'b1, mcuReset);
		rd("kept over usb reset", 32'h10);
		usbFuncReset <= 1'b0;
		u_fw.fwWrite(8'hc3);
		rd("fields set", 32'hc3);
		chkWord("outputs", 32'hf, {28'h0, outs});
		u_fw.xfer(1'b1, UFC_CTRL_OFFSET, 32'h0c, q, e);
		rd("reserved stay zero", 32'h0);
		chkWord("outputs cleared", 32'h0, {28'h0, outs});
		usbFuncReset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chkBit("mcu reset apart", 1'b0, mcuReset);
		usbFuncReset <= 1'b0;
		p0 = pulseCnt;
		u_fw.fwWrite(8'h20);
		rd("wakeup running", 32'h20);
		repeat (WAKE + 4) @(posedge clk_sys);
		chkWord("pulse length", WAKE, pulseCnt - p0);
		rd("wakeup self clear", 32'h0);
		u_fw.fwWrite(8'h00);
		repeat (4) @(posedge clk_sys);
		chkWord("no pulse on zero", WAKE, pulseCnt - p0);
		// write with lane 0 strobe low must not land
		u_fw.strbSel = 4'h0;
		u_fw.xfer(1'b1, UFC_CTRL_OFFSET, 32'hff, q, e);
		u_fw.strbSel = 4'h1;
		repeat (4) @(posedge clk_sys);
		chkWord("no pulse strobe off", WAKE, pulseCnt - p0);
		rd("strobe off ignored", 32'h0);
		u_fw.xfer(1'b1, 8'h04, 32'hff, q, e);
		chkBit("unmapped write err", 1'b1, e);
		u_fw.xfer(1'b0, 8'h04, 32'h0, q, e);
		chkWord("unmapped read", 32'h0, q);
		rd("unmapped write ignored", 32'h0);
		// power-up reset in mid-run clears what firmware set
		u_fw.fwWrite(8'h83);
		rd("set before reset", 32'h83);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chkWord("outputs in reset", 32'h0, {28'h0, outs});
		rst_n <= 1'b1;
		rd("reset value again", 32'h10);
		give_verdict();
	end
endmodule

/* verif/ufc_fw_master.sv */
/* apb master standing in for the firmware.
   assumes clk_sys from the bench and a slave that raises pready. */
`timescale 1ns/1ps
module ufc_fw_master (
	// clock
	input  wire logic        clk_sys,
	// apb request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	// apb answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int timeouts = 0;
	// lane strobe used on writes; reads drive no strobe
	logic [3:0] strbSel = 4'h1;
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// one transfer, held until pready is sampled high; bounded wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? strbSel : 4'h0;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		e = pslverr;
		timeouts += (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// firmware never sets the reserved bits
	task automatic fwWrite(input logic [7:0] v);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, 8'h00, {24'h0, v & 8'hf3}, q, e);
	endtask
endmodule
